// [ca_parity_map.svh]
// constants of the command/address parity checker: field layout, codes, timing
// assumes a command clock period given by the includer for the ns-to-cycle conversion
`ifndef CA_PARITY_MAP_SVH
`define CA_PARITY_MAP_SVH

// frame layout {cid, bg, ba, act_n, addr}
`define CAPAR_ADDR_W        18
`define CAPAR_FRAME_W       26
`define CAPAR_LOG_W         27

// parity latency field codes
`define CAPAR_PL_OFF        3'h0
`define CAPAR_PL_4          3'h1
`define CAPAR_PL_5          3'h2
`define CAPAR_PL_6          3'h3
`define CAPAR_PL_8          3'h4

// error sequence times and link clock period in ns
`define CAPAR_ONSET_NS      160
`define CAPAR_PW_MIN_NS     1280
`define CAPAR_PW_MAX_NS     1920
`define CAPAR_RAS_MIN_NS    640
`define CAPAR_LINK_PER_NS   160

// reset values
`define CAPAR_STATUS_RST    1'b0
`define CAPAR_ALERT_N_RST   1'b1

`endif

// [ca_parity_pkg.sv]
// types shared by the command/address parity checker
// assumes ca_parity_map.svh for all numeric constants
package ca_parity_pkg;

    // gray order along idle -> alert -> drain -> hold -> idle
    typedef enum logic [1:0]
    {
        ST_IDLE  = 2'b00,
        ST_ALERT = 2'b01,
        ST_DRAIN = 2'b11,
        ST_HOLD  = 2'b10
    } err_state_t;

endpackage

// [ca_level_sync.sv]
// two-flop synchroniser for quasi-static levels
// assumes the source changes rarely and multi-bit values change only while idle
`timescale 1ns/1ns
`default_nettype none

module ca_level_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] meta_r;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_r <= '0;
            q      <= '0;
        end
        else
        begin
            meta_r <= d;
            q      <= meta_r;
        end
    end

endmodule

`default_nettype wire

// [ca_cmd_delay.sv]
// command hold line: flop storage, read at an index set by the parity latency
// assumes tap = latency - 1 and a flush that kills every queued command
`timescale 1ns/1ns
`default_nettype none

module ca_cmd_delay #(
    parameter int W = 26,
    parameter int D = 8
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         flush,
    input  wire logic         in_valid,
    input  wire logic [W-1:0] in_frame,
    input  wire logic [2:0]   tap,
    output logic              out_valid,
    output logic      [W-1:0] out_frame
);

    logic [D-1:0] vld_r;
    logic [W-1:0] frm_r [D];

    assign out_valid = vld_r[tap] & ~flush;
    assign out_frame = frm_r[tap];

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            vld_r <= '0;
        else if (flush)
            vld_r <= '0;
        else
            vld_r <= {vld_r[D-2:0], in_valid};
    end

    always_ff @(posedge clk)
    begin
        frm_r[0] <= in_frame;
        for (int i = 1; i < D; i++)
            frm_r[i] <= frm_r[i-1];
    end

endmodule

`default_nettype wire

// [ca_parity_checker.sv]
// command/address parity checker: capture, even parity, latency hold, alert sequence
// assumes pins are synchronous to link_clk; control and status live on clock
//
// What this block does
// - parity covers act, ras/cas/we, address, bank, bank group, stack select lines
// - unused or unconnected address inputs count as zero in parity
// - frame is valid when ones over covered inputs plus parity input are even
// - latency codes 1 to 4 enable checking and map to 4, 5, 6, 8 clocks; codes 5 to 7 disable it
// - every chip-selected command is held parity-latency cycles before execution
// - parity latency is added to read and write latency
// - erroneous command discarded; commands just before it may be dropped
// - parity error with write crc enabled resets the crc error status bit
// - failing command and address bits are stored in a readable error log
// - error sets status bit before alert is released
// - alert driven low within onset delay of the erroneous command
// - no execution during alert window; after row-active minimum precharge all
// - alert released only after minimum pulse width and precharged state
// - after maximum pulse width accept commands; unchecked until status cleared
// - log keeps first error until status cleared or a second error
// - latency write-only, status read/write, log read-only
// - persistent mode resumes checking when the error sequence returns to idle after maximum pulse width
`timescale 1ns/1ns
`default_nettype none
`include "ca_parity_map.svh"

module ca_parity_checker #(
    parameter logic [17:0] ADDR_USED = 18'h3ffff,
    parameter logic [2:0]  CID_USED  = 3'h0,
    parameter int          PER_NS    = `CAPAR_LINK_PER_NS
) (
    input  wire logic        clock,
    input  wire logic        resetn,
    input  wire logic        link_clk,
    input  wire logic        cs_n,
    input  wire logic        act_n,
    input  wire logic [17:0] addr,
    input  wire logic [1:0]  bg,
    input  wire logic [1:0]  ba,
    input  wire logic [2:0]  cid,
    input  wire logic        par_in,
    input  wire logic [2:0]  pl_code,
    input  wire logic        persist_mode,
    input  wire logic        status_wr,
    input  wire logic        status_wdata,
    input  wire logic [5:0]  add_lat,
    input  wire logic [5:0]  cas_lat,
    input  wire logic [5:0]  cas_wr_lat,
    output logic             alert_n,
    output logic             exec_valid,
    output logic      [25:0] exec_frame,
    output logic             prechg_all,
    output logic             status_bit,
    output logic      [26:0] err_log,
    output logic             crc_err_clear,
    output logic      [6:0]  rd_latency,
    output logic      [6:0]  wr_latency
);

    localparam int ONSET_CYC = `CAPAR_ONSET_NS / PER_NS;
    localparam int PW_MIN    = (`CAPAR_PW_MIN_NS + PER_NS - 1) / PER_NS;
    localparam int PW_MAX    = `CAPAR_PW_MAX_NS / PER_NS;
    localparam int RAS_CYC   = (`CAPAR_RAS_MIN_NS + PER_NS - 1) / PER_NS;

    function automatic logic [3:0] pl_cycles(input logic [2:0] code);
        case (code)
            `CAPAR_PL_4: pl_cycles = 4'h4;
            `CAPAR_PL_5: pl_cycles = 4'h5;
            `CAPAR_PL_6: pl_cycles = 4'h6;
            `CAPAR_PL_8: pl_cycles = 4'h8;
            default:     pl_cycles = 4'h0;
        endcase
    endfunction

    // link-domain reset: asynchronous assert, synchronous release
    logic [1:0] lrst_r;
    logic       link_rst_n;
    always_ff @(posedge link_clk or negedge resetn)
    begin
        if (!resetn)
            lrst_r <= 2'h0;
        else
            lrst_r <= {lrst_r[0], 1'b1};
    end
    assign link_rst_n = lrst_r[1];

    // control into the link domain
    logic [4:0] cfg_l;
    logic       status_l;
    ca_level_sync #(.W(5)) u_cfg_sync (
        .clk   (link_clk),
        .rst_n (link_rst_n),
        .d     ({status_bit, persist_mode, pl_code}),
        .q     (cfg_l)
    );
    wire [2:0] pl_l      = cfg_l[2:0];
    wire       persist_l = cfg_l[3];
    assign status_l      = cfg_l[4];
    wire [3:0] pl_cyc_l  = pl_cycles(pl_l);
    wire       pl_en_l   = (pl_cyc_l != 4'h0);

    // capture of chip-selected frames
    logic                       cmd_v_r;
    logic [`CAPAR_FRAME_W-1:0]  frame_r;
    logic                       par_r;
    always_ff @(posedge link_clk or negedge link_rst_n)
    begin
        if (!link_rst_n)
            cmd_v_r <= 1'b0;
        else
            cmd_v_r <= ~cs_n;
    end
    always_ff @(posedge link_clk)
    begin
        frame_r <= {cid & CID_USED, bg, ba, act_n, addr & ADDR_USED};
        par_r   <= par_in;
    end

    ca_parity_pkg::err_state_t state_r;
    ca_parity_pkg::err_state_t state_nxt;
    logic [7:0] cnt_r;
    logic       blocked_r;
    logic       seen_r;

    wire idle_l     = (state_r == ca_parity_pkg::ST_IDLE);
    wire par_bad    = ^{frame_r, par_r};
    wire chk_on     = pl_en_l & ~blocked_r & idle_l;
    wire err_det    = cmd_v_r & chk_on & par_bad;
    wire good_in    = cmd_v_r & idle_l & ~err_det;

    // hold line; an error flushes commands still queued
    logic                      dly_v;
    logic [`CAPAR_FRAME_W-1:0] dly_f;
    ca_cmd_delay #(.W(`CAPAR_FRAME_W), .D(8)) u_delay (
        .clk       (link_clk),
        .rst_n     (link_rst_n),
        .flush     (err_det),
        .in_valid  (good_in),
        .in_frame  (frame_r),
        .tap       (3'(pl_cyc_l - 4'h1)),
        .out_valid (dly_v),
        .out_frame (dly_f)
    );

    wire                      exec_v_nxt = pl_en_l ? (dly_v & idle_l) : good_in;
    wire [`CAPAR_FRAME_W-1:0] exec_f_nxt = pl_en_l ? dly_f : frame_r;

    // error sequence
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            ca_parity_pkg::ST_IDLE:
                if (err_det)
                    state_nxt = ca_parity_pkg::ST_ALERT;
            ca_parity_pkg::ST_ALERT:
                if (cnt_r >= 8'(RAS_CYC))
                    state_nxt = ca_parity_pkg::ST_DRAIN;
            ca_parity_pkg::ST_DRAIN:
                if (cnt_r >= 8'(PW_MIN))
                    state_nxt = ca_parity_pkg::ST_HOLD;
            ca_parity_pkg::ST_HOLD:
                if (cnt_r >= 8'(PW_MAX))
                    state_nxt = ca_parity_pkg::ST_IDLE;
            default:
                state_nxt = ca_parity_pkg::ST_IDLE;
        endcase
    end

    wire alert_nxt   = (state_nxt == ca_parity_pkg::ST_ALERT) |
                       (state_nxt == ca_parity_pkg::ST_DRAIN);
    wire prechg_nxt  = (state_r == ca_parity_pkg::ST_ALERT) &
                       (state_nxt == ca_parity_pkg::ST_DRAIN);

    logic [`CAPAR_LOG_W-1:0] log_l_r;
    logic                    err_tgl_r;
    logic                    pre_done_r;

    always_ff @(posedge link_clk or negedge link_rst_n)
    begin
        if (!link_rst_n)
        begin
            state_r    <= ca_parity_pkg::ST_IDLE;
            cnt_r      <= 8'h00;
            alert_n    <= `CAPAR_ALERT_N_RST;
            prechg_all <= 1'b0;
            pre_done_r <= 1'b0;
            exec_valid <= 1'b0;
            exec_frame <= '0;
            err_tgl_r  <= 1'b0;
            log_l_r    <= '0;
        end
        else
        begin
            state_r    <= state_nxt;
            cnt_r      <= (state_nxt == ca_parity_pkg::ST_IDLE) ? 8'h00 : cnt_r + 8'h01;
            alert_n    <= ~alert_nxt;
            prechg_all <= prechg_nxt;
            pre_done_r <= err_det ? 1'b0 : (pre_done_r | prechg_nxt);
            exec_valid <= exec_v_nxt;
            exec_frame <= exec_f_nxt;
            if (err_det)
            begin
                err_tgl_r <= ~err_tgl_r;
                log_l_r   <= {par_r, frame_r};
            end
        end
    end

    // non-persistent mode stops checking until status is seen set then cleared
    always_ff @(posedge link_clk or negedge link_rst_n)
    begin
        if (!link_rst_n)
        begin
            blocked_r <= 1'b0;
            seen_r    <= 1'b0;
        end
        else if (err_det)
        begin
            blocked_r <= ~persist_l;
            seen_r    <= 1'b0;
        end
        else if (blocked_r)
        begin
            seen_r <= seen_r | status_l;
            if (seen_r && !status_l)
                blocked_r <= 1'b0;
        end
    end

    // error event into the clock domain
    logic err_s;
    logic err_s_d_r;
    ca_level_sync #(.W(1)) u_err_sync (
        .clk   (clock),
        .rst_n (resetn),
        .d     (err_tgl_r),
        .q     (err_s)
    );
    wire err_evt  = err_s ^ err_s_d_r;
    wire clr_wr   = status_wr & ~status_wdata;
    wire [3:0] pl_cyc_c = pl_cycles(pl_code);

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            err_s_d_r     <= 1'b0;
            status_bit    <= `CAPAR_STATUS_RST;
            err_log       <= '0;
            crc_err_clear <= 1'b0;
            rd_latency    <= 7'h00;
            wr_latency    <= 7'h00;
        end
        else
        begin
            err_s_d_r     <= err_s;
            status_bit    <= err_evt | (status_bit & ~clr_wr);
            crc_err_clear <= err_evt;
            if (err_evt)
                err_log <= log_l_r;
            rd_latency    <= 7'(add_lat) + 7'(cas_lat) + 7'(pl_cyc_c);
            wr_latency    <= 7'(add_lat) + 7'(cas_wr_lat) + 7'(pl_cyc_c);
        end
    end

    sequence good_pl4_s;
        good_in && pl_cyc_l == 4'h4 ##1 (idle_l && !err_det && pl_cyc_l == 4'h4)[*4];
    endsequence

    alert_onset_a: assert property (@(posedge link_clk) disable iff (!link_rst_n)
        err_det |-> ##[1:ONSET_CYC] !alert_n)
        else $error("alert not driven low after parity error");
    parity_even_a: assert property (@(posedge link_clk) disable iff (!link_rst_n)
        err_det |-> cmd_v_r && ((^frame_r) != par_r))
        else $error("error flagged on an even frame");
    no_exec_alert_a: assert property (@(posedge link_clk) disable iff (!link_rst_n)
        !alert_n |=> !exec_valid)
        else $error("command executed in alert window");
    release_after_pw_a: assert property (@(posedge link_clk) disable iff (!link_rst_n)
        $rose(alert_n) |-> cnt_r > 8'(PW_MIN) && pre_done_r)
        else $error("alert released too early");
    latency_hold_a: assert property (@(posedge link_clk) disable iff (!link_rst_n)
        good_pl4_s |=> exec_valid)
        else $error("command not executed after parity latency");
    unchecked_a: assert property (@(posedge link_clk) disable iff (!link_rst_n)
        blocked_r && cmd_v_r |-> !err_det)
        else $error("parity checked while status pending");
    log_capture_a: assert property (@(posedge link_clk) disable iff (!link_rst_n)
        err_det |=> log_l_r == $past({par_r, frame_r}))
        else $error("error frame not logged");
    status_set_a: assert property (@(posedge clock) disable iff (!resetn)
        err_evt |=> status_bit && crc_err_clear)
        else $error("status or crc clear missing after error");
    status_wr1_a: assert property (@(posedge clock) disable iff (!resetn)
        status_wr && status_wdata && !status_bit && !err_evt |=> !status_bit)
        else $error("write of one reached status bit");
    status_clr_a: assert property (@(posedge clock) disable iff (!resetn)
        clr_wr && !err_evt |=> !status_bit)
        else $error("status bit not cleared by zero write");

endmodule

`default_nettype wire

// [ca_ctrl_model.sv]
// controller model: drives one command frame per call, with even or broken parity
// assumes a free-running link_clk from the bench; frames launch on its falling edge
`timescale 1ns/1ns
`default_nettype none

module ca_ctrl_model (
    input  wire logic        link_clk,
    input  wire logic        alert_n,
    output logic             cs_n,
    output logic             act_n,
    output logic      [17:0] addr,
    output logic      [1:0]  bg,
    output logic      [1:0]  ba,
    output logic      [2:0]  cid,
    output logic             par_in
);
    initial
    begin
        cs_n = 1'b1;
        {act_n, addr, bg, ba, cid, par_in} = 27'h0;
    end

    // bad inverts the parity bit; returns after the capturing rise and the release
    task automatic issue(input logic [17:0] a, input logic bad);
        // only deselects while alert is low, for at most 40 falling edges
        for (int i = 0; i < 40 && alert_n !== 1'b1; i++) @(negedge link_clk);
        @(negedge link_clk);
        cs_n = 1'b0;
        act_n = ~a[17];
        addr = a;
        bg = 2'h2;
        ba = 2'h1;
        // stack lines unconnected: driven, but left out of the parity
        cid = 3'h5;
        par_in = ^{~a[17], a, 2'h2, 2'h1} ^ bad;
        @(posedge link_clk);
        @(negedge link_clk);
        cs_n = 1'b1;
        // deselected lines show the inverse of their last value
        {act_n, addr, bg, ba, cid, par_in} = ~{act_n, addr, bg, ba, cid, par_in};
    endtask
endmodule

`default_nettype wire

// [tb_ca_parity_checker.sv]
// testbench of the command/address parity checker
// assumes ca_ctrl_model as the command source; status and modes driven on clock
`timescale 1ns/1ns
`default_nettype none

module tb_ca_parity_checker;
    logic        clock, resetn, link_clk, alert_n, exec_valid, prechg_all, status_bit;
    logic        cs_n, act_n, par_in, persist_mode, status_wr, status_wdata, crc_err_clear;
    logic [17:0] addr;
    logic [5:0]  add_lat, cas_lat, cas_wr_lat;
    logic [1:0]  bg, ba;
    logic [2:0]  cid, pl_code;
    logic [25:0] exec_frame, got_frame;
    logic [26:0] err_log;
    logic [6:0]  rd_latency, wr_latency;
    int          err_total, n_compared, n_exec, n_pre, n_crc, low_len, last_low;
    int          lat, k, e0, p0, c0, pc;

    ca_ctrl_model ca_ctrl_model_i (.link_clk(link_clk), .alert_n(alert_n), .cs_n(cs_n),
        .act_n(act_n), .addr(addr), .bg(bg), .ba(ba), .cid(cid), .par_in(par_in));

    ca_parity_checker ca_parity_checker_i (.clock(clock), .resetn(resetn),
        .link_clk(link_clk), .cs_n(cs_n), .act_n(act_n), .addr(addr), .bg(bg), .ba(ba),
        .cid(cid), .par_in(par_in), .pl_code(pl_code), .persist_mode(persist_mode),
        .status_wr(status_wr), .status_wdata(status_wdata), .add_lat(add_lat),
        .cas_lat(cas_lat), .cas_wr_lat(cas_wr_lat), .alert_n(alert_n), .exec_valid(exec_valid),
        .exec_frame(exec_frame), .prechg_all(prechg_all), .status_bit(status_bit),
        .err_log(err_log), .crc_err_clear(crc_err_clear), .rd_latency(rd_latency),
        .wr_latency(wr_latency));

    initial
    begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    initial
    begin
        link_clk = 1'b0;
        #37;
        forever #80 link_clk = ~link_clk;
    end

    always @(posedge link_clk)
    begin
        if (exec_valid === 1'b1) n_exec++;
        if (prechg_all === 1'b1) n_pre++;
        if (alert_n === 1'b0) low_len++;
        else if (low_len != 0)
        begin
            last_low = low_len;
            low_len = 0;
        end
    end

    always @(posedge clock) if (crc_err_clear === 1'b1) n_crc++;

    function automatic logic [25:0] frm(input logic [17:0] a);
        return {3'h0, 2'h2, 2'h1, ~a[17], a};
    endfunction

    task automatic close_out;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic link_wait(input int n);
        repeat (n) @(posedge link_clk);
        @(negedge clock);
    endtask

    // latency changes always pass through the disabled code
    task automatic set_pl(input logic [2:0] c);
        @(negedge clock);
        pl_code = 3'h0;
        link_wait(6);
        pl_code = c;
        link_wait(6);
    endtask

    task automatic wr_status(input logic d);
        @(negedge clock);
        status_wr = 1'b1;
        status_wdata = d;
        @(negedge clock);
        status_wr = 1'b0;
        link_wait(6);
    endtask

    task automatic run(input logic [17:0] a, input logic bad, output int n);
        ca_ctrl_model_i.issue(a, bad);
        n = 99;
        for (int i = 1; i < 20 && n == 99; i++)
        begin
            @(posedge link_clk);
            #1;
            if (exec_valid === 1'b1)
            begin
                n = i;
                got_frame = exec_frame;
            end
        end
    endtask

    // link edges until alert_n shows v; running out of the bound ends the run
    task automatic wait_alert(input logic v, output int n);
        n = 0;
        while (alert_n !== v)
        begin
            if (n == 40)
            begin
                err_total++;
                close_out;
            end
            @(posedge link_clk);
            #1;
            n++;
        end
    endtask

    initial
    begin
        {resetn, persist_mode, status_wr, status_wdata, pl_code} = 7'h0;
        {add_lat, cas_lat, cas_wr_lat} = 18'h0;
        repeat (5) @(negedge clock);
        resetn = 1'b1;
        link_wait(8);
        for (int c = 0; c < 8; c++)
        begin
            set_pl(c[2:0]);
            add_lat = 6'(c);
            cas_lat = 6'h11;
            cas_wr_lat = 6'h0c;
            pc = (c == 1) ? 4 : (c == 2) ? 5 : (c == 3) ? 6 : (c == 4) ? 8 : 0;
            run(18'h2a5a5 ^ c, 1'b0, lat);
            check(lat, 1 + pc);
            check(got_frame, frm(18'h2a5a5 ^ c));
            check(rd_latency, c + 17 + pc);
            check(wr_latency, c + 12 + pc);
        end
        set_pl(3'h1);
        e0 = n_exec;
        p0 = n_pre;
        c0 = n_crc;
        ca_ctrl_model_i.issue(18'h01234, 1'b0);
        ca_ctrl_model_i.issue(18'h3c0f1, 1'b1);
        wait_alert(1'b0, k);
        check(k, 1);
        wait_alert(1'b1, k);
        check(status_bit, 1'b1);
        link_wait(6);
        check(last_low >= 8 && last_low <= 12, 1);
        check(n_pre - p0, 1);
        check(n_exec - e0, 0);
        check(n_crc - c0, 1);
        check(err_log, {~^frm(18'h3c0f1), frm(18'h3c0f1)});
        run(18'h15555, 1'b1, lat);
        check(lat, 5);
        check(alert_n, 1'b1);
        check(err_log, {~^frm(18'h3c0f1), frm(18'h3c0f1)});
        wr_status(1'b0);
        check(status_bit, 1'b0);
        wr_status(1'b1);
        check(status_bit, 1'b0);
        ca_ctrl_model_i.issue(18'h0aaaa, 1'b1);
        wait_alert(1'b0, k);
        check(k, 1);
        wait_alert(1'b1, k);
        link_wait(6);
        check(err_log, {~^frm(18'h0aaaa), frm(18'h0aaaa)});
        // clear the pending error so checking is unblocked before the persistent run; the log is kept
        wr_status(1'b0);
        check(status_bit, 1'b0);
        persist_mode = 1'b1;
        link_wait(6);
        ca_ctrl_model_i.issue(18'h30303, 1'b1);
        wait_alert(1'b0, k);
        check(k, 1);
        wait_alert(1'b1, k);
        check(status_bit, 1'b1);
        link_wait(6);
        check(err_log, {~^frm(18'h30303), frm(18'h30303)});
        // status still set: a second error must be caught; its log is not trusted
        ca_ctrl_model_i.issue(18'h0c3c3, 1'b1);
        wait_alert(1'b0, k);
        check(k, 1);
        check(status_bit, 1'b1);
        wait_alert(1'b1, k);
        link_wait(6);
        close_out;
    end
endmodule

`default_nettype wire
